// *** rci_bcd_counter.sv ***
// one packed-BCD time field that counts, wraps and loads
// assumes the caller gives lo and hi bounds in BCD
`timescale 1ns/10ps
module rci_bcd_counter #(
  parameter logic [7:0] RST_VAL = 8'h00
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic inc,
  input wire logic load,
  input wire logic [7:0] load_val,
  input wire logic [7:0] lo_val,
  input wire logic [7:0] hi_val,
  output logic [7:0] value,
  output logic carry
);
  rci_pkg::rci_bcd_s st, nx;

  // load wins over a count; out-of-range values wrap too
  always_comb begin
    nx = st;
    if (load) begin
      nx.value = load_val;
    end else if (inc) begin
      if (st.value >= hi_val) begin
        nx.value = lo_val;
      end else if (st.value[3:0] == 4'h9) begin
        nx.value = {st.value[7:4] + 4'h1, 4'h0};
      end else begin
        nx.value = {st.value[7:4], st.value[3:0] + 4'h1};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st.value <= RST_VAL;
    end else begin
      st <= nx;
    end
  end

  assign value = st.value;
  assign carry = inc && !load && (st.value >= hi_val);
endmodule

// *** rci_half_tick.sv ***
// half-second divider on oscillator pulses with per-minute drift trim
// assumes osc_tick is a one-cycle enable pulse per oscillator period
`timescale 1ns/10ps
module rci_half_tick #(
  parameter int HALF_PULSES = 16384,
  parameter int SYNC_PULSES = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic osc_tick,
  input wire logic run,
  input wire logic minute_start,
  input wire logic [7:0] cal,
  input wire logic clear,
  output logic half_tick,
  output logic sec_tick,
  output logic half_flag,
  output logic near_end
);
  rci_pkg::rci_half_s st, nx;
  logic [16:0] adj4;
  logic [16:0] limit;

  // first half-second of each minute is shortened or stretched by 4 x cal
  assign adj4 = {{7{cal[7]}}, cal, 2'b00};
  assign limit = 17'(HALF_PULSES - 1) - (st.adj ? adj4 : 17'h00000);

  always_comb begin
    nx = st;
    nx.hp = 1'b0;
    nx.sp = 1'b0;
    nx.near = st.half && ((st.cnt + 17'(SYNC_PULSES)) >= limit);
    if (minute_start) begin
      nx.adj = 1'b1;
    end
    if (clear) begin
      nx.cnt = 17'h00000;
      nx.half = 1'b0;
    end else if (run && osc_tick) begin
      if (st.cnt >= limit) begin
        nx.cnt = 17'h00000;
        nx.half = ~st.half;
        nx.hp = 1'b1;
        nx.sp = st.half;
        nx.adj = 1'b0;
      end else begin
        nx.cnt = st.cnt + 17'h00001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign half_tick = st.hp;
  assign sec_tick = st.sp;
  assign half_flag = st.half;
  assign near_end = st.near;
endmodule

// *** rci_pkg.sv ***
// types shared by the clock and calendar design files
// no surroundings assumed
package rci_pkg;
  typedef enum logic [1:0] {RCI_UNL_IDLE = 2'b00, RCI_UNL_KEY1 = 2'b01} rci_unlock_e;
  typedef enum logic [3:0] {
    RCI_M_HALF = 4'b0000, RCI_M_SEC = 4'b0001, RCI_M_10S = 4'b0010, RCI_M_MIN = 4'b0011,
    RCI_M_10M = 4'b0100, RCI_M_HOUR = 4'b0101, RCI_M_DAY = 4'b0110, RCI_M_WEEK = 4'b0111,
    RCI_M_MONTH = 4'b1000, RCI_M_YEAR = 4'b1001
  } rci_mask_e;
  typedef struct packed {
    logic [7:0] sec, min, hour, wday, day, month, year;
  } rci_time_s;
  typedef struct packed {logic [7:0] value;} rci_bcd_s;
  typedef struct packed {
    logic [16:0] cnt;
    logic half, adj, hp, sp, near;
  } rci_half_s;
  typedef struct packed {
    logic en, wren, oe;
    logic [1:0] tptr;
    logic [7:0] cal;
    logic pad_sel, pad_ttl;
    logic [15:0] alm_cfg;
    logic [7:0] a_min, a_sec, a_wd, a_hr, a_mon, a_day;
    rci_unlock_e unl;
    logic [1:0] arm;
    logic dph_wr, dph_rd;
    logic [7:0] dph_addr;
    logic hready;
    logic [31:0] hrdata;
    logic [11:0] osc_cnt;
    logic osc_tick, hp_d, sp_d, alarm_pulse, pin, pin_en;
  } rci_top_s;
endpackage

// *** rci_regs.svh ***
// register offsets, field positions, reset values and timing counts
// included by the top module and its self-checking bench only
`ifndef RCI_REGS_SVH
`define RCI_REGS_SVH
`define RCI_OFS_CFG 8'h00
`define RCI_OFS_TIME_HI 8'h04
`define RCI_OFS_TIME_LO 8'h08
`define RCI_OFS_ALM_CFG 8'h0C
`define RCI_OFS_ALM_HI 8'h10
`define RCI_OFS_ALM_LO 8'h14
`define RCI_OFS_PAD 8'h18
`define RCI_OFS_UNLOCK 8'h1C
`define RCI_CFG_EN 15
`define RCI_CFG_WREN 13
`define RCI_CFG_OE 10
`define RCI_PTR_HI 9
`define RCI_PTR_LO 8
`define RCI_ALM_EN 15
`define RCI_MASK_HI 13
`define RCI_MASK_LO 10
`define RCI_PAD_SEL 1
`define RCI_PAD_TTL 0
`define RCI_KEY1 8'h55
`define RCI_KEY2 8'hAA
`define RCI_CFG_RST 13'h0000
`define RCI_ALM_RST 16'h0000
`define RCI_PAD_RST 1'b0
`define RCI_SEC_RST 8'h00
`define RCI_ONE_RST 8'h01
`define RCI_SEC_MAX 8'h59
`define RCI_HR_MAX 8'h23
`define RCI_MON_MAX 8'h12
`define RCI_YR_MAX 8'h99
`define RCI_WD_MAX 8'h06
`define RCI_HCLK_HZ 100000000
`define RCI_OSC_HZ 32768
`define RCI_OSC_DIV (`RCI_HCLK_HZ / `RCI_OSC_HZ)
`define RCI_HALF_SEC_MS 500
`define RCI_HALF_PULSES (`RCI_OSC_HZ * `RCI_HALF_SEC_MS / 1000)
`define RCI_SYNC_PULSES 32
`define RCI_UNLOCK_CYC 2'h3
`endif

// *** rci_top.sv ***
// clock and calendar: AHB-Lite register slave, value windows, timekeeping
// assumes one AHB-Lite master, single word transfers, hclk at 100 MHz
//
// Functional notes
// - keep time and date at half-second steps
// - weekday and leap years in hardware, 2000-2099
// - all time values are packed BCD
// - oscillator and clock survive external master reset
// - time pointer selects the time register pair
// - high time byte write decrements pointer
// - any value window read decrements its pointer
// - alarm pointer selects the alarm register pair
// - high alarm byte write decrements alarm pointer
// - time writes only while write enable set
// - write enable settable only after unlock
// - module enable runs clock, write-locked
// - sync flag warns of rollover ripple
// - half-second flag, cleared by seconds write
// - output enable drives the clock pin
// - pad select picks seconds clock or alarm
// - calibration trims 4 pulses per step per minute
// - configuration reset only at power-on
// - pad bit picks parallel input buffers
// - alarm mask picks the alarm interval
//
// Added by the designer: register access over AHB-Lite and the register addresses.
`timescale 1ns/10ps
`include "rci_regs.svh"
module rci_top #(
  parameter int HALF_PULSES = `RCI_HALF_PULSES,
  parameter int OSC_DIV = `RCI_OSC_DIV,
  parameter int SYNC_PULSES = `RCI_SYNC_PULSES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic external_master_reset,
  output logic clock_calendar_out,
  output logic clock_calendar_out_en,
  output logic parallel_input_buffer_select
);
  rci_pkg::rci_top_s st, nx;
  rci_pkg::rci_time_s tm;
  logic take, ld_ok, ld_hi, ld_lo, ld_sec;
  logic half_tick, sec_tick, half_flag, near_end, read_sync_flag;
  logic c_sec, c_min, c_hr, c_day, c_mon;
  logic leap;
  logic [7:0] day_max;
  logic [31:0] rdata;
  logic hit, s_eq, m_eq, h_eq;

  // address phase taken only for word transfers while ready
  assign take = hsel && hready && st.hready && htrans[1] && (hsize == 3'h2);

  // accepted value writes, steered by the time pointer
  assign ld_ok = st.dph_wr && st.wren;
  assign ld_hi = ld_ok && (st.dph_addr == `RCI_OFS_TIME_HI);
  assign ld_lo = ld_ok && (st.dph_addr == `RCI_OFS_TIME_LO);
  assign ld_sec = ld_lo && (st.tptr == 2'h0);

  // divider and trim feeding the second counter
  rci_half_tick #(
    .HALF_PULSES(HALF_PULSES),
    .SYNC_PULSES(SYNC_PULSES)
  ) u_half (
    .hclk(hclk),
    .hresetn(hresetn),
    .osc_tick(st.osc_tick),
    .run(st.en),
    .minute_start(c_sec),
    .cal(st.cal),
    .clear(ld_sec),
    .half_tick(half_tick),
    .sec_tick(sec_tick),
    .half_flag(half_flag),
    .near_end(near_end)
  );

  // leap years: every year divisible by four inside 2000-2099
  assign leap = tm.year[4] ? (tm.year[3:0] == 4'h2 || tm.year[3:0] == 4'h6) :
                (tm.year[3:0] == 4'h0 || tm.year[3:0] == 4'h4 || tm.year[3:0] == 4'h8);

  // last day of the current month
  always_comb begin
    unique case (tm.month)
      8'h02: day_max = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: day_max = 8'h30;
      default: day_max = 8'h31;
    endcase
  end

  // bcd time chain, carries ripple from seconds upward
  rci_bcd_counter #(.RST_VAL(`RCI_SEC_RST)) u_sec (
    .hclk(hclk), .hresetn(hresetn), .inc(sec_tick), .load(ld_sec),
    .load_val(hwdata[7:0]), .lo_val(8'h00), .hi_val(`RCI_SEC_MAX),
    .value(tm.sec), .carry(c_sec)
  );
  rci_bcd_counter #(.RST_VAL(`RCI_SEC_RST)) u_min (
    .hclk(hclk), .hresetn(hresetn), .inc(c_sec), .load(ld_hi && st.tptr == 2'h0),
    .load_val(hwdata[7:0]), .lo_val(8'h00), .hi_val(`RCI_SEC_MAX),
    .value(tm.min), .carry(c_min)
  );
  rci_bcd_counter #(.RST_VAL(`RCI_SEC_RST)) u_hour (
    .hclk(hclk), .hresetn(hresetn), .inc(c_min), .load(ld_lo && st.tptr == 2'h1),
    .load_val(hwdata[7:0]), .lo_val(8'h00), .hi_val(`RCI_HR_MAX),
    .value(tm.hour), .carry(c_hr)
  );
  rci_bcd_counter #(.RST_VAL(`RCI_SEC_RST)) u_wday (
    .hclk(hclk), .hresetn(hresetn), .inc(c_hr), .load(ld_hi && st.tptr == 2'h1),
    .load_val({5'h00, hwdata[2:0]}), .lo_val(8'h00), .hi_val(`RCI_WD_MAX),
    .value(tm.wday), .carry()
  );
  rci_bcd_counter #(.RST_VAL(`RCI_ONE_RST)) u_day (
    .hclk(hclk), .hresetn(hresetn), .inc(c_hr), .load(ld_lo && st.tptr == 2'h2),
    .load_val(hwdata[7:0]), .lo_val(8'h01), .hi_val(day_max),
    .value(tm.day), .carry(c_day)
  );
  rci_bcd_counter #(.RST_VAL(`RCI_ONE_RST)) u_mon (
    .hclk(hclk), .hresetn(hresetn), .inc(c_day), .load(ld_hi && st.tptr == 2'h2),
    .load_val(hwdata[7:0]), .lo_val(8'h01), .hi_val(`RCI_MON_MAX),
    .value(tm.month), .carry(c_mon)
  );
  rci_bcd_counter #(.RST_VAL(`RCI_SEC_RST)) u_year (
    .hclk(hclk), .hresetn(hresetn), .inc(c_mon), .load(ld_lo && st.tptr == 2'h3),
    .load_val(hwdata[7:0]), .lo_val(8'h00), .hi_val(`RCI_YR_MAX),
    .value(tm.year), .carry()
  );

  assign read_sync_flag = near_end && st.en;

  // read multiplexer, window bytes chosen by their pointers
  always_comb begin
    rdata = 32'h00000000;
    unique case (st.dph_addr)
      `RCI_OFS_CFG: rdata = {16'h0000, st.en, 1'b0, st.wren, read_sync_flag, half_flag,
                             st.oe, st.tptr, st.cal};
      `RCI_OFS_TIME_HI: begin
        unique case (st.tptr)
          2'h0: rdata[7:0] = tm.min;
          2'h1: rdata[7:0] = tm.wday;
          2'h2: rdata[7:0] = tm.month;
          2'h3: rdata[7:0] = 8'h00;
        endcase
      end
      `RCI_OFS_TIME_LO: begin
        unique case (st.tptr)
          2'h0: rdata[7:0] = tm.sec;
          2'h1: rdata[7:0] = tm.hour;
          2'h2: rdata[7:0] = tm.day;
          2'h3: rdata[7:0] = tm.year;
        endcase
      end
      `RCI_OFS_ALM_CFG: rdata[15:0] = st.alm_cfg;
      `RCI_OFS_ALM_HI: begin
        unique case (st.alm_cfg[`RCI_PTR_HI:`RCI_PTR_LO])
          2'h0: rdata[7:0] = st.a_min;
          2'h1: rdata[7:0] = st.a_wd;
          2'h2: rdata[7:0] = st.a_mon;
          2'h3: rdata[7:0] = 8'h00;
        endcase
      end
      `RCI_OFS_ALM_LO: begin
        unique case (st.alm_cfg[`RCI_PTR_HI:`RCI_PTR_LO])
          2'h0: rdata[7:0] = st.a_sec;
          2'h1: rdata[7:0] = st.a_hr;
          2'h2: rdata[7:0] = st.a_day;
          2'h3: rdata[7:0] = 8'h00;
        endcase
      end
      `RCI_OFS_PAD: rdata[1:0] = {st.pad_sel, st.pad_ttl};
      default: rdata = 32'h00000000;
    endcase
  end

  // alarm match against the time as it stands after each step
  assign s_eq = tm.sec == st.a_sec;
  assign m_eq = s_eq && tm.min == st.a_min;
  assign h_eq = m_eq && tm.hour == st.a_hr;
  always_comb begin
    unique case (rci_pkg::rci_mask_e'(st.alm_cfg[`RCI_MASK_HI:`RCI_MASK_LO]))
      rci_pkg::RCI_M_HALF: hit = st.hp_d;
      rci_pkg::RCI_M_SEC: hit = st.sp_d;
      rci_pkg::RCI_M_10S: hit = st.sp_d && tm.sec[3:0] == st.a_sec[3:0];
      rci_pkg::RCI_M_MIN: hit = st.sp_d && s_eq;
      rci_pkg::RCI_M_10M: hit = st.sp_d && s_eq && tm.min[3:0] == st.a_min[3:0];
      rci_pkg::RCI_M_HOUR: hit = st.sp_d && m_eq;
      rci_pkg::RCI_M_DAY: hit = st.sp_d && h_eq;
      rci_pkg::RCI_M_WEEK: hit = st.sp_d && h_eq && tm.wday == st.a_wd;
      rci_pkg::RCI_M_MONTH: hit = st.sp_d && h_eq && tm.day == st.a_day;
      rci_pkg::RCI_M_YEAR: hit = st.sp_d && h_eq && tm.day == st.a_day && tm.month == st.a_mon;
      default: hit = 1'b0; // reserved codes never fire
    endcase
  end

  // bus slave, control registers, pointers and the output pin
  always_comb begin
    nx = st;
    nx.hready = 1'b1;
    nx.dph_rd = 1'b0;
    nx.dph_wr = 1'b0;
    nx.hp_d = half_tick;
    nx.sp_d = sec_tick;
    // oscillator pulse divider, untouched by master reset
    if (st.osc_cnt >= 12'(OSC_DIV - 1)) begin
      nx.osc_cnt = 12'h000;
      nx.osc_tick = 1'b1;
    end else begin
      nx.osc_cnt = st.osc_cnt + 12'h001;
      nx.osc_tick = 1'b0;
    end
    if (st.arm != 2'h0) begin
      nx.arm = st.arm - 2'h1;
    end
    if (take) begin
      nx.dph_addr = haddr[7:0];
      nx.dph_wr = hwrite;
      nx.dph_rd = !hwrite;
      nx.hready = hwrite; // one wait state on reads
    end
    // read completes; value window reads step the pointer down
    if (st.dph_rd) begin
      nx.hrdata = rdata;
      if ((st.dph_addr == `RCI_OFS_TIME_HI || st.dph_addr == `RCI_OFS_TIME_LO) &&
          st.tptr != 2'h0) begin
        nx.tptr = st.tptr - 2'h1;
      end
      if ((st.dph_addr == `RCI_OFS_ALM_HI || st.dph_addr == `RCI_OFS_ALM_LO) &&
          st.alm_cfg[`RCI_PTR_HI:`RCI_PTR_LO] != 2'h0) begin
        nx.alm_cfg[`RCI_PTR_HI:`RCI_PTR_LO] = st.alm_cfg[`RCI_PTR_HI:`RCI_PTR_LO] - 2'h1;
      end
    end
    // write data phase
    if (st.dph_wr) begin
      unique case (st.dph_addr)
        `RCI_OFS_CFG: begin
          if (st.wren) begin
            nx.en = hwdata[`RCI_CFG_EN];
          end
          nx.wren = hwdata[`RCI_CFG_WREN] && (st.wren || st.arm != 2'h0);
          nx.oe = hwdata[`RCI_CFG_OE];
          nx.tptr = hwdata[`RCI_PTR_HI:`RCI_PTR_LO];
          nx.cal = hwdata[7:0];
        end
        `RCI_OFS_TIME_HI: begin
          if (st.tptr != 2'h0) begin
            nx.tptr = st.tptr - 2'h1;
          end
        end
        `RCI_OFS_ALM_CFG: nx.alm_cfg = hwdata[15:0];
        `RCI_OFS_ALM_HI: begin
          unique case (st.alm_cfg[`RCI_PTR_HI:`RCI_PTR_LO])
            2'h0: nx.a_min = hwdata[7:0];
            2'h1: nx.a_wd = hwdata[7:0];
            2'h2: nx.a_mon = hwdata[7:0];
            2'h3: nx.a_min = st.a_min;
          endcase
          if (st.alm_cfg[`RCI_PTR_HI:`RCI_PTR_LO] != 2'h0) begin
            nx.alm_cfg[`RCI_PTR_HI:`RCI_PTR_LO] = st.alm_cfg[`RCI_PTR_HI:`RCI_PTR_LO] - 2'h1;
          end
        end
        `RCI_OFS_ALM_LO: begin
          unique case (st.alm_cfg[`RCI_PTR_HI:`RCI_PTR_LO])
            2'h0: nx.a_sec = hwdata[7:0];
            2'h1: nx.a_hr = hwdata[7:0];
            2'h2: nx.a_day = hwdata[7:0];
            2'h3: nx.a_sec = st.a_sec;
          endcase
        end
        `RCI_OFS_PAD: begin
          nx.pad_sel = hwdata[`RCI_PAD_SEL];
          nx.pad_ttl = hwdata[`RCI_PAD_TTL];
        end
        `RCI_OFS_UNLOCK: begin
          if (hwdata[7:0] == `RCI_KEY1) begin
            nx.unl = rci_pkg::RCI_UNL_KEY1;
          end else begin
            nx.unl = rci_pkg::RCI_UNL_IDLE;
            if (st.unl == rci_pkg::RCI_UNL_KEY1 && hwdata[7:0] == `RCI_KEY2) begin
              nx.arm = `RCI_UNLOCK_CYC;
            end
          end
        end
        default: nx.unl = st.unl;
      endcase
    end
    // alarm pulse lasts until the next half-second step
    if (hit && st.alm_cfg[`RCI_ALM_EN]) begin
      nx.alarm_pulse = 1'b1;
    end else if (st.hp_d) begin
      nx.alarm_pulse = 1'b0;
    end
    nx.pin_en = st.oe;
    nx.pin = st.oe && (st.pad_sel ? half_flag : st.alarm_pulse);
    // master reset clears pad and unlock state only
    if (external_master_reset) begin
      nx.pad_sel = `RCI_PAD_RST;
      nx.pad_ttl = `RCI_PAD_RST;
      nx.unl = rci_pkg::RCI_UNL_IDLE;
      nx.arm = 2'h0;
    end
  end

  // only the power-on reset clears configuration
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
      {st.en, st.wren, st.oe, st.tptr, st.cal} <= `RCI_CFG_RST;
      st.alm_cfg <= `RCI_ALM_RST;
      st.hready <= 1'b1;
    end else begin
      st <= nx;
    end
  end

  assign hreadyout = st.hready;
  assign hresp = 1'b0;
  assign hrdata = st.hrdata;
  assign clock_calendar_out = st.pin;
  assign clock_calendar_out_en = st.pin_en;
  assign parallel_input_buffer_select = st.pad_ttl;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  chk_tptr_write_dec: assert property (
    (st.dph_wr && st.dph_addr == `RCI_OFS_TIME_HI && st.tptr != 2'h0)
      |=> st.tptr == $past(st.tptr) - 2'h1)
    else $error("time pointer not stepped by high write");
  chk_tptr_hold_zero: assert property (
    (st.dph_wr && st.dph_addr == `RCI_OFS_TIME_HI && st.tptr == 2'h0) |=> st.tptr == 2'h0)
    else $error("time pointer left zero");
  chk_tptr_read_dec: assert property (
    (st.dph_rd && st.dph_addr == `RCI_OFS_TIME_LO && st.tptr != 2'h0)
      |=> st.tptr == $past(st.tptr) - 2'h1)
    else $error("time pointer not stepped by read");
  chk_aptr_write_dec: assert property (
    (st.dph_wr && st.dph_addr == `RCI_OFS_ALM_HI && st.alm_cfg[9:8] != 2'h0)
      |=> st.alm_cfg[9:8] == $past(st.alm_cfg[9:8]) - 2'h1)
    else $error("alarm pointer not stepped by high write");
  chk_lock_ignores: assert property (
    (st.dph_wr && st.dph_addr == `RCI_OFS_TIME_LO && !st.wren && !sec_tick) |=> $stable(tm.sec))
    else $error("locked time write took effect");
  chk_wren_unlock: assert property (
    $rose(st.wren) |-> $past(st.arm) != 2'h0)
    else $error("write enable set without unlock");
  chk_en_locked: assert property (
    !st.wren |=> $stable(st.en))
    else $error("module enable changed while locked");
  chk_half_clear: assert property (
    ld_sec |=> !half_flag)
    else $error("half-second flag not cleared by seconds write");
  chk_pin_gate: assert property (
    !st.oe |=> !clock_calendar_out_en ##0 !clock_calendar_out)
    else $error("clock pin driven while output disabled");
  chk_rsv_read_zero: assert property (
    (take && !hwrite && haddr[7:0] == `RCI_OFS_TIME_HI && st.tptr == 2'h3 && !st.dph_wr)
      |=> s_rd_wait ##0 hrdata == 32'h00000000)
    else $error("reserved window byte read not zero");
endmodule

// *** rci_top_tb.sv ***
// self-checking bench for the clock and calendar register slave
// assumes rci_top with short divider counts and this bench as sole AHB-Lite master
`timescale 1ns/10ps
`include "rci_regs.svh"
module rci_top_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic external_master_reset = 1'b0;
  logic hreadyout, hresp, pin, pin_en, buf_sel;
  logic [31:0] hrdata, rd, r2;
  int mismatches = 0;
  int tests_run = 0;

  // half second is 600 osc pulses of 2 hclk each
  rci_top #(.HALF_PULSES(600), .OSC_DIV(2), .SYNC_PULSES(8)) i_rci_top (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .external_master_reset(external_master_reset),
    .clock_calendar_out(pin),
    .clock_calendar_out_en(pin_en),
    .parallel_input_buffer_select(buf_sel)
  );

  // 100 MHz clock
  always #5 hclk = ~hclk;

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one single AHB-Lite transfer, entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] q);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    q = hrdata;
    if (n >= 50) begin
      mismatches++;
      $display("[ERR] %0t bus transfer timed out", $time);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  // reset values, unmapped place
  task automatic t_reset;
    rdchk(`RCI_OFS_CFG, 32'h0);
    rdchk(`RCI_OFS_PAD, 32'h0);
    wr(8'h40, 32'hFFFFFFFF);
    rdchk(8'h40, 32'h0);
    chk({31'h0, hresp}, 32'h0);
  endtask

  // locked writes, late unlock, then a proper unlock
  task automatic t_lock;
    wr(`RCI_OFS_CFG, 32'hA400);
    rdchk(`RCI_OFS_CFG, 32'h0400);
    chk({31'h0, pin_en}, 32'h1);
    wr(`RCI_OFS_TIME_LO, 32'h12);
    rdchk(`RCI_OFS_TIME_LO, 32'h0);
    wr(`RCI_OFS_UNLOCK, 32'h55);
    wr(`RCI_OFS_UNLOCK, 32'hAA);
    repeat (5) @(posedge hclk);
    wr(`RCI_OFS_CFG, 32'h2000);
    rdchk(`RCI_OFS_CFG, 32'h0);
    chk({31'h0, pin_en}, 32'h0);
    wr(`RCI_OFS_UNLOCK, 32'h55);
    wr(`RCI_OFS_UNLOCK, 32'hAA);
    wr(`RCI_OFS_CFG, 32'h2300);
    rdchk(`RCI_OFS_CFG, 32'h2300);
  endtask

  // time window walk from pointer 3 down to 0
  task automatic t_time;
    wr(`RCI_OFS_TIME_LO, 32'h25);
    wr(`RCI_OFS_TIME_HI, 32'h77);
    wr(`RCI_OFS_TIME_LO, 32'h31);
    wr(`RCI_OFS_TIME_HI, 32'h12);
    wr(`RCI_OFS_TIME_LO, 32'h23);
    wr(`RCI_OFS_TIME_HI, 32'h05);
    wr(`RCI_OFS_TIME_LO, 32'h30);
    wr(`RCI_OFS_TIME_HI, 32'h45);
    rdchk(`RCI_OFS_CFG, 32'h2000);
    wr(`RCI_OFS_CFG, 32'h2300);
    rdchk(`RCI_OFS_TIME_HI, 32'h0);
    rdchk(`RCI_OFS_CFG, 32'h2200);
    wr(`RCI_OFS_CFG, 32'h2300);
    rdchk(`RCI_OFS_TIME_LO, 32'h25);
    rdchk(`RCI_OFS_TIME_HI, 32'h12);
    rdchk(`RCI_OFS_TIME_LO, 32'h23);
    rdchk(`RCI_OFS_TIME_HI, 32'h45);
    rdchk(`RCI_OFS_TIME_LO, 32'h30);
  endtask

  // alarm mask codes and alarm window walk
  task automatic t_alarm;
    for (int m = 0; m < 10; m++) begin
      wr(`RCI_OFS_ALM_CFG, {16'h0, 2'b10, m[3:0], 10'h0});
      rdchk(`RCI_OFS_ALM_CFG, {16'h0, 2'b10, m[3:0], 10'h0});
    end
    wr(`RCI_OFS_ALM_CFG, 32'h0300);
    rdchk(`RCI_OFS_ALM_LO, 32'h0);
    wr(`RCI_OFS_ALM_HI, 32'h11);
    wr(`RCI_OFS_ALM_LO, 32'h22);
    wr(`RCI_OFS_ALM_HI, 32'h03);
    wr(`RCI_OFS_ALM_HI, 32'h59);
    rdchk(`RCI_OFS_ALM_CFG, 32'h0);
    wr(`RCI_OFS_ALM_CFG, 32'h0200);
    rdchk(`RCI_OFS_ALM_HI, 32'h11);
    rdchk(`RCI_OFS_ALM_LO, 32'h22);
    rdchk(`RCI_OFS_ALM_HI, 32'h59);
  endtask

  // running clock: half flag, pin, BCD rollover, sync flag
  task automatic t_run;
    wr(`RCI_OFS_PAD, 32'h3);
    rdchk(`RCI_OFS_PAD, 32'h3);
    chk({31'h0, buf_sel}, 32'h1);
    wr(`RCI_OFS_CFG, 32'hA400);
    wr(`RCI_OFS_TIME_LO, 32'h59);
    repeat (1800) @(posedge hclk);
    xfer(1'b0, `RCI_OFS_CFG, 32'h0, rd);
    chk(rd & 32'h0800, 32'h0800);
    chk({30'h0, pin_en, pin}, 32'h3);
    wr(`RCI_OFS_TIME_LO, 32'h59);
    xfer(1'b0, `RCI_OFS_CFG, 32'h0, rd);
    chk(rd & 32'h0800, 32'h0);
    repeat (2405) @(posedge hclk);
    rdchk(`RCI_OFS_TIME_LO, 32'h00);
    rdchk(`RCI_OFS_TIME_HI, 32'h46);
    r2 = 32'h0;
    for (int i = 0; i < 900 && r2 == 32'h0; i++) begin
      xfer(1'b0, `RCI_OFS_CFG, 32'h0, rd);
      r2 = rd & 32'h1000;
    end
    chk(r2, 32'h1000);
  endtask

  // external master reset leaves config and timekeeping alone
  task automatic t_emr;
    xfer(1'b0, `RCI_OFS_TIME_LO, 32'h0, r2);
    external_master_reset <= 1'b1;
    repeat (3) @(posedge hclk);
    external_master_reset <= 1'b0;
    xfer(1'b0, `RCI_OFS_CFG, 32'h0, rd);
    chk(rd & 32'hE7FF, 32'hA400);
    rdchk(`RCI_OFS_PAD, 32'h0);
    repeat (2400) @(posedge hclk);
    xfer(1'b0, `RCI_OFS_TIME_LO, 32'h0, rd);
    chk({31'h0, rd !== r2}, 32'h1);
  endtask

  // leap-day rollover, minute alarm on the pin, trimmed first half-second
  task automatic t_cal;
    logic [7:0] v [8] = '{8'h24, 8'h00, 8'h28, 8'h02, 8'h23, 8'h03, 8'h59, 8'h59};
    wr(`RCI_OFS_CFG, 32'h237F);
    for (int i = 0; i < 8; i++) begin
      wr(i[0] ? `RCI_OFS_TIME_HI : `RCI_OFS_TIME_LO, {24'h0, v[i]});
    end
    wr(`RCI_OFS_ALM_CFG, 32'h8C00);
    wr(`RCI_OFS_CFG, 32'hA47F);
    repeat (2500) @(posedge hclk);
    chk({31'h0, pin}, 32'h1);
    repeat (200) @(posedge hclk);
    xfer(1'b0, `RCI_OFS_CFG, 32'h0, rd);
    chk(rd & 32'h0800, 32'h0800);
    wr(`RCI_OFS_CFG, 32'hA67F);
    rdchk(`RCI_OFS_TIME_LO, 32'h29);
    rdchk(`RCI_OFS_TIME_HI, 32'h04);
    rdchk(`RCI_OFS_TIME_HI, 32'h00);
  endtask

  // disabled clock holds time; enable locked once write enable clears
  task automatic t_disable;
    wr(`RCI_OFS_CFG, 32'h2400);
    xfer(1'b0, `RCI_OFS_TIME_LO, 32'h0, r2);
    repeat (2500) @(posedge hclk);
    rdchk(`RCI_OFS_TIME_LO, r2);
    wr(`RCI_OFS_CFG, 32'h0);
    wr(`RCI_OFS_CFG, 32'h8000);
    xfer(1'b0, `RCI_OFS_CFG, 32'h0, rd);
    chk(rd & 32'hE7FF, 32'h0);
  endtask

  // verdict and end of run
  task automatic report_and_stop;
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_lock;
    t_time;
    t_alarm;
    t_run;
    t_emr;
    t_cal;
    t_disable;
    report_and_stop;
  end

  // watchdog, well beyond the expected run
  initial begin
    #1000000;
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop;
  end
endmodule
